// ---- hw/lcdext_pkg.sv ----
// Constants, types and lookup shared by the extension instruction decoder
package lcdext_pkg;
  // Register port layout
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 16;
  localparam logic [3:0]  REG_INSTR    = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h1;
  localparam logic [3:0]  REG_POWER    = 4'h2;
  localparam logic [3:0]  REG_CONTRAST = 4'h3;
  localparam logic [3:0]  REG_FRAME    = 4'h4;

  // Opcode upper nibbles of the extension table
  localparam logic [3:0]  NIB_BIAS_OSC  = 4'h1;
  localparam logic [3:0]  NIB_ICON_ADDR = 4'h4;
  localparam logic [3:0]  NIB_POWER     = 4'h5;
  localparam logic [3:0]  NIB_FOLLOWER  = 4'h6;
  localparam logic [3:0]  NIB_CONTR_LO  = 4'h7;
  // Function set: upper three bits 001, table select in bit 0
  localparam logic [2:0]  FUNC_SET_TOP  = 3'h1;
  localparam int          BIT_TABLE_SEL = 0;

  // Field positions inside instruction bytes
  localparam int          BIT_ICON_ON   = 3;
  localparam int          BIT_BOOST_ON  = 2;
  localparam int          BIT_FOLLOW_ON = 3;
  localparam int          BIT_BIAS_SEL  = 3;

  // Reset values
  localparam logic [2:0]  RST_OSC_TRIM  = 3'h0;
  localparam logic [2:0]  RST_GAIN      = 3'h0;
  localparam logic [5:0]  RST_CONTRAST  = 6'h00;
  localparam logic [6:0]  RST_ADDR      = 7'h00;

  // Busy time after an accepted instruction
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          BUSY_TIME_NS  = 26300;
  localparam int          BUSY_CYCLES   = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_FUNC_SET,
    OP_BIAS_OSC,
    OP_ICON_ADDR,
    OP_POWER,
    OP_FOLLOWER,
    OP_CONTR_LO
  } lcdext_op_t;

  // Frame rate in Hz, two-line mode, 5 V column
  function automatic logic [8:0] frame_rate_hz(input logic [2:0] code);
    case (code)
      3'h0:    frame_rate_hz = 9'h078;
      3'h1:    frame_rate_hz = 9'h085;
      3'h2:    frame_rate_hz = 9'h095;
      3'h3:    frame_rate_hz = 9'h0a7;
      3'h4:    frame_rate_hz = 9'h0c0;
      3'h5:    frame_rate_hz = 9'h0e3;
      3'h6:    frame_rate_hz = 9'h115;
      default: frame_rate_hz = 9'h15b;
    endcase
  endfunction
endpackage

// ---- hw/lcdext_cmd_if.sv ----
// Interface joining the decoder top to its opcode decoder and busy timer
`timescale 1ns/1ns
interface lcdext_cmd_if;
  logic [7:0]             instr;
  logic                   is_ext;
  lcdext_pkg::lcdext_op_t op;
  logic                   start;
  logic                   busy;

  modport top   (output instr, output is_ext, input op, output start, input busy);
  modport dec   (input instr, input is_ext, output op);
  modport timer (input start, output busy);
endinterface

// ---- hw/lcdext_opdec.sv ----
// Combinational opcode classifier for normal and extension tables
`timescale 1ns/1ns
module lcdext_opdec (
  lcdext_cmd_if.dec cmd  // Instruction in, opcode class out
);
  always_comb begin
    cmd.op = lcdext_pkg::OP_NONE;
    if (cmd.instr[7:5] == lcdext_pkg::FUNC_SET_TOP) begin
      cmd.op = lcdext_pkg::OP_FUNC_SET;
    end else if (cmd.is_ext) begin
      case (cmd.instr[7:4])
        lcdext_pkg::NIB_BIAS_OSC:  cmd.op = lcdext_pkg::OP_BIAS_OSC;
        lcdext_pkg::NIB_ICON_ADDR: cmd.op = lcdext_pkg::OP_ICON_ADDR;
        lcdext_pkg::NIB_POWER:     cmd.op = lcdext_pkg::OP_POWER;
        lcdext_pkg::NIB_FOLLOWER:  cmd.op = lcdext_pkg::OP_FOLLOWER;
        lcdext_pkg::NIB_CONTR_LO:  cmd.op = lcdext_pkg::OP_CONTR_LO;
        default:                   cmd.op = lcdext_pkg::OP_NONE;
      endcase
    end
  end
endmodule

// ---- hw/lcdext_busy.sv ----
// Busy timer started by each accepted instruction
`timescale 1ns/1ns
module lcdext_busy #(
  parameter int CYCLES = lcdext_pkg::BUSY_CYCLES  // Busy length in clocks
) (
  input  wire logic   i_clk,     // System clock
  input  wire logic   i_reset,   // Synchronous reset, active high
  input  wire logic   i_clk_en,  // Clock enable
  lcdext_cmd_if.timer cmd        // Start in, busy out
);
  logic [12:0] count;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count <= 13'h0000;
    end else if (i_clk_en) begin
      if (cmd.start) begin
        count <= 13'(CYCLES);
      end else if (count != 13'h0000) begin
        count <= count - 13'h0001;
      end
    end
  end

  assign cmd.busy = (count != 13'h0000);
endmodule

// ---- hw/lcdext_decoder.sv ----
// Extension instruction decoder top: register port, settings and status
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ns
module lcdext_decoder #(
  parameter int BUSY_CYCLES = lcdext_pkg::BUSY_CYCLES  // Busy length in clocks
) (
  input  wire logic                          i_clk,                    // 50 MHz clock
  input  wire logic                          i_reset,                  // Sync reset, high
  input  wire logic                          i_clk_en,                 // Freezes state when low
  input  wire logic [lcdext_pkg::ADDR_W-1:0] i_addr,                   // Register address
  input  wire logic [lcdext_pkg::DATA_W-1:0] i_wdata,                  // Write data
  input  wire logic                          i_wr,                     // Write strobe
  input  wire logic                          i_rd,                     // Read strobe
  output logic      [lcdext_pkg::DATA_W-1:0] o_rdata,                  // Read data, next cycle
  input  wire logic                          i_clock_source_select_pin,// Internal osc strap
  input  wire logic                          i_follower_strap_a,       // Follower option a
  input  wire logic                          i_follower_strap_b,       // Follower option b
  output logic                               o_instr_table_select,     // Extension table on
  output logic                               o_busy_flag,              // Instruction in progress
  output logic      [2:0]                    o_osc_trim_code,          // Oscillator trim
  output logic      [8:0]                    o_frame_rate_hz,          // Nominal frame rate
  output logic                               o_bias_select,            // 1: 1/4, 0: 1/5 bias
  output logic      [6:0]                    o_address_counter,        // Address counter
  output logic                               o_icon_on,                // Icon display on
  output logic                               o_booster_on,             // Booster on
  output logic                               o_follower_on,            // Follower on
  output logic      [2:0]                    o_v0_gain_ratio,          // V0 gain ratio
  output logic      [5:0]                    o_contrast                // Contrast value
);
  lcdext_cmd_if cmd ();

  lcdext_opdec u_opdec (
    .cmd (cmd.dec)
  );

  lcdext_busy #(
    .CYCLES (BUSY_CYCLES)
  ) u_busy (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_clk_en (i_clk_en),
    .cmd      (cmd.timer)
  );

  logic       accept;
  logic       internal_follower;
  logic       contrast_allowed;
  logic       bias_allowed;
  logic [1:0] contrast_upper;
  logic [3:0] contrast_lower;
  logic [7:0] instr;

  assign instr = i_wdata[7:0];

  assign accept     = i_clk_en && i_wr && (i_addr == lcdext_pkg::REG_INSTR) && !cmd.busy;
  assign cmd.instr  = instr;
  assign cmd.is_ext = o_instr_table_select;
  assign cmd.start  = accept;

  assign internal_follower = !i_follower_strap_a && !i_follower_strap_b;
  // Contrast trims the internal follower reference, so it needs that follower
  assign contrast_allowed  = internal_follower;
  // Bias is meaningless with external bias resistors, so it is held then
  assign bias_allowed      = !(i_follower_strap_a && i_follower_strap_b);

  assign o_busy_flag = cmd.busy;
  assign o_contrast  = {contrast_upper, contrast_lower};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_instr_table_select <= 1'b0;
    end else if (accept && cmd.op == lcdext_pkg::OP_FUNC_SET) begin
      o_instr_table_select <= instr[lcdext_pkg::BIT_TABLE_SEL];
    end
  end

  // Bias and oscillator trim
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_bias_select   <= 1'b0;
      o_osc_trim_code <= lcdext_pkg::RST_OSC_TRIM;
    end else if (accept && cmd.op == lcdext_pkg::OP_BIAS_OSC) begin
      if (bias_allowed) begin
        o_bias_select <= instr[lcdext_pkg::BIT_BIAS_SEL];
      end
      if (i_clock_source_select_pin) begin
        o_osc_trim_code <= instr[2:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_frame_rate_hz <= lcdext_pkg::frame_rate_hz(lcdext_pkg::RST_OSC_TRIM);
    end else if (i_clk_en) begin
      o_frame_rate_hz <= lcdext_pkg::frame_rate_hz(o_osc_trim_code);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_address_counter <= lcdext_pkg::RST_ADDR;
    end else if (accept && cmd.op == lcdext_pkg::OP_ICON_ADDR) begin
      o_address_counter <= {3'h0, instr[3:0]};
    end
  end

  // Power, icon and contrast-high instruction
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_icon_on      <= 1'b0;
      o_booster_on   <= 1'b0;
      contrast_upper <= lcdext_pkg::RST_CONTRAST[5:4];
    end else if (accept && cmd.op == lcdext_pkg::OP_POWER) begin
      o_icon_on <= instr[lcdext_pkg::BIT_ICON_ON];
      if (internal_follower) begin
        o_booster_on <= instr[lcdext_pkg::BIT_BOOST_ON];
      end
      if (contrast_allowed) begin
        contrast_upper <= instr[1:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      contrast_lower <= lcdext_pkg::RST_CONTRAST[3:0];
    end else if (accept && cmd.op == lcdext_pkg::OP_CONTR_LO && contrast_allowed) begin
      contrast_lower <= instr[3:0];
    end
  end

  // Follower control instruction
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_follower_on   <= 1'b0;
      o_v0_gain_ratio <= lcdext_pkg::RST_GAIN;
    end else if (accept && cmd.op == lcdext_pkg::OP_FOLLOWER && internal_follower) begin
      o_follower_on   <= instr[lcdext_pkg::BIT_FOLLOW_ON];
      o_v0_gain_ratio <= instr[2:0];
    end
  end

  // Read data stand until the next enabled clock after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else if (i_clk_en) begin
      o_rdata <= 16'h0000;
      if (i_rd) begin
        case (i_addr)
          lcdext_pkg::REG_STATUS:
            o_rdata <= {7'h00, o_instr_table_select, cmd.busy, o_address_counter};
          lcdext_pkg::REG_POWER:
            o_rdata <= {8'h00, o_v0_gain_ratio, o_bias_select, o_follower_on,
                        o_booster_on, o_icon_on, 1'b0};
          lcdext_pkg::REG_CONTRAST:
            o_rdata <= {7'h00, o_osc_trim_code, o_contrast};
          lcdext_pkg::REG_FRAME:
            o_rdata <= {7'h00, o_frame_rate_hz};
          default:
            o_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule

// ---- sim/lcdext_decoder_checker.sv ----
// Port assertions for the extension instruction decoder
`timescale 1ns/1ns
module lcdext_decoder_checker #(
  parameter int BUSY_CYCLES = lcdext_pkg::BUSY_CYCLES  // Busy length in clocks
) (
  input wire logic        i_clk,                     // Clock
  input wire logic        i_reset,                   // Reset
  input wire logic        i_clk_en,                  // Enable
  input wire logic [3:0]  i_addr,                    // Address
  input wire logic [15:0] i_wdata,                   // Write data
  input wire logic        i_wr,                      // Write strobe
  input wire logic        i_clock_source_select_pin, // Osc strap
  input wire logic        i_follower_strap_a,        // Strap a
  input wire logic        i_follower_strap_b,        // Strap b
  input wire logic        o_instr_table_select,      // Table
  input wire logic        o_busy_flag,               // Busy
  input wire logic [2:0]  o_osc_trim_code,           // Trim
  input wire logic [8:0]  o_frame_rate_hz,           // Frame rate
  input wire logic [6:0]  o_address_counter,         // Address
  input wire logic        o_booster_on,              // Booster
  input wire logic        o_follower_on,             // Follower
  input wire logic [2:0]  o_v0_gain_ratio,           // Gain
  input wire logic [5:0]  o_contrast                 // Contrast
);
  logic       acc;
  logic       ext;
  logic       intf;
  logic [3:0] nib;
  int         busy_cnt;
  assign acc  = i_clk_en && i_wr && i_addr == lcdext_pkg::REG_INSTR && !o_busy_flag;
  assign ext  = acc && o_instr_table_select;
  assign intf = !i_follower_strap_a && !i_follower_strap_b;
  assign nib  = i_wdata[7:4];
  // Length of the current busy run, read at its falling edge
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_busy_flag) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  busy_start_a: assert property (acc |=> o_busy_flag)
    else $error("busy did not rise");
  busy_len_a: assert property ($fell(o_busy_flag) |-> busy_cnt == BUSY_CYCLES)
    else $error("busy length wrong");
  table_sel_a: assert property (acc && i_wdata[7:5] == lcdext_pkg::FUNC_SET_TOP
    |=> o_instr_table_select == $past(i_wdata[0])) else $error("table select wrong");
  osc_hold_a: assert property (ext && nib == lcdext_pkg::NIB_BIAS_OSC
    && !i_clock_source_select_pin |=> $stable(o_osc_trim_code)) else $error("trim moved");
  trim_load_a: assert property (ext && nib == lcdext_pkg::NIB_BIAS_OSC
    && i_clock_source_select_pin |=> o_osc_trim_code == $past(i_wdata[2:0]))
    else $error("trim not loaded");
  frame_rise_a: assert property (o_osc_trim_code > $past(o_osc_trim_code)
    |=> o_frame_rate_hz > $past(o_frame_rate_hz)) else $error("frame rate not rising");
  icon_addr_a: assert property (ext && nib == lcdext_pkg::NIB_ICON_ADDR
    |=> o_address_counter == {3'h0, $past(i_wdata[3:0])}) else $error("icon address wrong");
  boost_gate_a: assert property (ext && nib == lcdext_pkg::NIB_POWER |=> o_booster_on
    == ($past(intf) ? $past(i_wdata[2]) : $past(o_booster_on))) else $error("booster wrong");
  follow_set_a: assert property (ext && nib == lcdext_pkg::NIB_FOLLOWER && intf
    |=> o_follower_on == $past(i_wdata[3]) && o_v0_gain_ratio == $past(i_wdata[2:0]))
    else $error("follower or gain wrong");
  contr_low_a: assert property (ext && nib == lcdext_pkg::NIB_CONTR_LO |=> o_contrast[3:0]
    == ($past(intf) ? $past(i_wdata[3:0]) : $past(o_contrast[3:0])))
    else $error("contrast low wrong");
  cover property (ext && nib == lcdext_pkg::NIB_POWER && intf);
  cover property (i_wr && i_addr == lcdext_pkg::REG_INSTR && o_busy_flag);
  cover property (o_osc_trim_code > $past(o_osc_trim_code));
endmodule
bind lcdext_decoder lcdext_decoder_checker #(.BUSY_CYCLES(BUSY_CYCLES)) checker_i (
  .i_clk, .i_reset, .i_clk_en, .i_addr, .i_wdata, .i_wr, .i_clock_source_select_pin,
  .i_follower_strap_a, .i_follower_strap_b, .o_instr_table_select, .o_busy_flag,
  .o_osc_trim_code, .o_frame_rate_hz, .o_address_counter, .o_booster_on, .o_follower_on,
  .o_v0_gain_ratio, .o_contrast);

// ---- sim/lcdext_host.sv ----
// Host model issuing instruction bytes and register reads
`timescale 1ns/1ns
module lcdext_host (
  input  wire logic        i_clk,   // Clock
  input  wire logic        i_busy,  // Busy flag
  input  wire logic [15:0] i_rdata, // Read data
  output logic      [3:0]  o_addr,  // Address
  output logic      [15:0] o_wdata, // Write data
  output logic             o_wr,    // Write strobe
  output logic             o_rd     // Read strobe
);
  initial begin
    o_addr  = 4'h0;
    o_wdata = 16'h0000;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    @(negedge i_clk);
    d = i_rdata;
  endtask
  task automatic idle(output logic late);
    int n;
    n = 0;
    @(negedge i_clk);
    while (i_busy !== 1'b0 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    // A busy flag that never drops is reported, not skipped
    late = (n >= 100);
  endtask
endmodule

// ---- sim/lcdext_decoder_test.sv ----
// Self-checking bench for the extension instruction decoder
`timescale 1ns/1ns
module lcdext_decoder_test;
  logic        i_clk, i_reset, pin, sa, sb, wr, rd, busy, tbl, icon, boost, fol, bias;
  logic        en, late;
  logic [3:0]  addr, nib;
  logic [15:0] wdata, rdata, d;
  logic [2:0]  trim, gain;
  logic [5:0]  con;
  logic [6:0]  ac;
  int          miscompares, checked;
  integer      seed = 32'h5373977e;
  int          fr[8] = '{120, 133, 149, 167, 192, 227, 277, 347};
  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;
  lcdext_host lcdext_host_i (.i_clk(i_clk), .i_busy(busy), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  lcdext_decoder #(.BUSY_CYCLES(4)) lcdext_decoder_i (.i_clk(i_clk), .i_reset(i_reset),
    .i_clk_en(en), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_clock_source_select_pin(pin), .i_follower_strap_a(sa), .i_follower_strap_b(sb),
    .o_instr_table_select(), .o_busy_flag(busy), .o_osc_trim_code(), .o_frame_rate_hz(),
    .o_bias_select(), .o_address_counter(), .o_icon_on(), .o_booster_on(),
    .o_follower_on(), .o_v0_gain_ratio(), .o_contrast());
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic exec(input logic [7:0] b);
    lcdext_host_i.idle(late);
    chk("idle", {15'h0000, late}, 16'h0000);
    lcdext_host_i.wr(lcdext_pkg::REG_INSTR, {8'h00, b});
    if (b[7:5] == 3'h1) begin
      tbl = b[0];
    end else if (tbl) begin
      case (b[7:4])
        4'h1: begin
          if (!(sa && sb)) bias = b[3];
          if (pin) trim = b[2:0];
        end
        4'h4: ac = {3'h0, b[3:0]};
        4'h5: begin
          icon = b[3];
          if (!sa && !sb) boost = b[2];
          if (!sa && !sb) con[5:4] = b[1:0];
        end
        4'h6: if (!sa && !sb) {fol, gain} = b[3:0];
        4'h7: if (!sa && !sb) con[3:0] = b[3:0];
        default: ;
      endcase
    end
  endtask
  task automatic check_all();
    lcdext_host_i.idle(late);
    chk("idle", {15'h0000, late}, 16'h0000);
    lcdext_host_i.rd(lcdext_pkg::REG_STATUS, d);
    chk("status", d, {7'h00, tbl, 1'b0, ac});
    lcdext_host_i.rd(lcdext_pkg::REG_POWER, d);
    chk("power", d, {8'h00, gain, bias, fol, boost, icon, 1'b0});
    lcdext_host_i.rd(lcdext_pkg::REG_CONTRAST, d);
    chk("contrast", d, {7'h00, trim, con});
    lcdext_host_i.rd(lcdext_pkg::REG_FRAME, d);
    chk("frame", d, 16'(fr[trim]));
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {i_reset, pin, sa, sb} = 4'h8;
    en = 1'b1;
    {tbl, icon, boost, fol, bias, trim, gain, con, ac} = '0;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    check_all();
    $display("test reset done");
    for (int k = 0; k < 300; k++) begin
      @(posedge i_clk);
      {sa, sb, pin} <= 3'($random(seed));
      nib = 4'(1 + $unsigned($random(seed)) % 7);
      // icon address only in extension table
      if (nib == 4'h4 && !tbl) nib = 4'h5;
      exec({nib, 4'($random(seed))});
      check_all();
    end
    $display("test random done");
    exec(8'h29);
    exec(8'h40);
    // Write while busy must be dropped
    lcdext_host_i.wr(lcdext_pkg::REG_INSTR, 16'h004f);
    lcdext_host_i.wr(lcdext_pkg::REG_STATUS, 16'h00ff);
    check_all();
    lcdext_host_i.rd(4'hf, d);
    chk("unmapped", d, 16'h0000);
    $display("test refuse done");
    // Instruction written while the enable is low must not land
    @(posedge i_clk);
    en <= 1'b0;
    lcdext_host_i.wr(lcdext_pkg::REG_INSTR, 16'h0041);
    en <= 1'b1;
    check_all();
    // The same instruction with the enable high does land
    exec(8'h41);
    check_all();
    $display("test enable done");
    wrap_up();
  end
  initial begin
    #600000;
    miscompares++;
    wrap_up();
  end
endmodule
